// ### rtl/dual_dac_cfg.svh
// Timing and field constants for the interleaved converter port
`ifndef DUAL_DAC_CFG_SVH
`define DUAL_DAC_CFG_SVH
`define WORD_W        14
`define WORD_MSB      13
`define CODE_FULL     15'h4000
`define CODE_MAX      14'h3FFF
`define MODE_INTERLEAVED 1'b0
`define HALF_PERIOD   4'h2
`define ALIGN_CYCLES  4'h3
`endif

// ### rtl/dual_dac_pkg.sv
// Shared types for the interleaved converter port
`default_nettype none
package dual_dac_pkg;
  typedef logic [13:0] word_t;
  typedef enum logic [1:0] {
    SRC_ALIGN  = 2'h0,
    SRC_WORD_A = 2'h1,
    SRC_WORD_B = 2'h3
  } src_state_t;
endpackage
`default_nettype wire

// ### rtl/interleaved_bus_if.sv
// Interface joining the baseband source and the converter input port
`timescale 1ns/1ps
`default_nettype none
interface interleaved_bus_if;
  import dual_dac_pkg::*;
  logic  sharedWriteStrobe;
  logic  sharedUpdateClock;
  logic  channelSelect;
  logic  pairAlignReset;
  logic  digitalGroundPin;
  word_t busA;
  word_t busB;
  modport source (
    output sharedWriteStrobe,
    output sharedUpdateClock,
    output channelSelect,
    output pairAlignReset,
    output digitalGroundPin,
    output busA,
    output busB
  );
  modport converter (
    input sharedWriteStrobe,
    input sharedUpdateClock,
    input channelSelect,
    input pairAlignReset,
    input digitalGroundPin,
    input busA,
    input busB
  );
endinterface
`default_nettype wire

// ### rtl/interleaved_dac_port.sv
// Converter end: interleaved input latches, halved clock and converter latches
`timescale 1ns/1ps
`default_nettype none
`include "dual_dac_cfg.svh"
module interleaved_dac_port #(
  parameter int WIDTH = `WORD_W
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 clkEn,
  // Link from the source
  interleaved_bus_if.converter      link,
  // Converter side
  output logic [WIDTH-1:0]          convCodeA,
  output logic [WIDTH-1:0]          convCodeB,
  output logic [WIDTH-1:0]          compCodeA,
  output logic [WIDTH-1:0]          compCodeB,
  output logic                      halvedConverterClock,
  output logic                      interleavedMode,
  output logic                      pairValid
);
  import dual_dac_pkg::*;

  // ----------------------------------------
  // Edge detection of shared strobe and clock
  // ----------------------------------------
  // Previous levels reset to the idle low so no false edge follows reset
  logic wrtPrev_reg, wrtPrev_next;
  logic clkPrev_reg, clkPrev_next;
  logic mode_reg, mode_next;
  logic wrtRise, wrtFall, updRise;
  assign wrtRise = link.sharedWriteStrobe & ~wrtPrev_reg;
  assign wrtFall = ~link.sharedWriteStrobe & wrtPrev_reg;
  assign updRise = link.sharedUpdateClock & ~clkPrev_reg;

  always_comb begin
    wrtPrev_next = link.sharedWriteStrobe;
    clkPrev_next = link.sharedUpdateClock;
    mode_next    = (link.digitalGroundPin == `MODE_INTERLEAVED);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wrtPrev_reg <= 1'b0;
      clkPrev_reg <= 1'b0;
      mode_reg    <= 1'b0;
    end else if (clkEn) begin
      wrtPrev_reg <= wrtPrev_next;
      clkPrev_reg <= clkPrev_next;
      mode_reg    <= mode_next;
    end
  end

  // ----------------------------------------
  // Pair tracking and halved converter clock
  // ----------------------------------------
  logic div_reg, div_next;
  logic gotA_reg, gotA_next;
  logic armed_reg, armed_next;
  logic pv_reg, pv_next;
  logic capA, capB, stageLoad, convLoad;
  // B bus never read here
  assign capA      = mode_reg & wrtRise & link.channelSelect;
  assign capB      = mode_reg & wrtRise & ~link.channelSelect;
  assign stageLoad = mode_reg & wrtFall;
  assign convLoad  = pv_next;

  always_comb begin
    div_next   = div_reg;
    gotA_next  = gotA_reg;
    armed_next = armed_reg;
    pv_next    = 1'b0;
    if (capA) begin
      gotA_next = 1'b1;
    end
    if (capB) begin
      if (gotA_reg) begin
        armed_next = 1'b1;
      end
      gotA_next = 1'b0;
    end
    if (link.pairAlignReset) begin
      div_next   = 1'b0;
      armed_next = 1'b0;
      gotA_next  = 1'b0;
    end else if (mode_reg && updRise && armed_reg) begin
      div_next = ~div_reg;
      pv_next  = ~div_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_reg   <= 1'b0;
      gotA_reg  <= 1'b0;
      armed_reg <= 1'b0;
      pv_reg    <= 1'b0;
    end else if (clkEn) begin
      div_reg   <= div_next;
      gotA_reg  <= gotA_next;
      armed_reg <= armed_next;
      pv_reg    <= pv_next;
    end
  end

  // ----------------------------------------
  // Channel latch paths, one per converter
  // ----------------------------------------
  // Both channels share one strobe and the halved clock
  channel_latch_path #(
    .WIDTH (WIDTH)
  ) u_channel_latch_path_a (
    .clk      (clk),
    .rst      (rst),
    .clkEn    (clkEn),
    .capture  (capA),
    .stage    (stageLoad),
    .load     (convLoad),
    .word     (link.busA[WIDTH-1:0]),
    .code     (convCodeA),
    .compCode (compCodeA)
  );

  channel_latch_path #(
    .WIDTH (WIDTH)
  ) u_channel_latch_path_b (
    .clk      (clk),
    .rst      (rst),
    .clkEn    (clkEn),
    .capture  (capB),
    .stage    (stageLoad),
    .load     (convLoad),
    .word     (link.busA[WIDTH-1:0]),
    .code     (convCodeB),
    .compCode (compCodeB)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign halvedConverterClock = div_reg;
  assign interleavedMode      = mode_reg;
  assign pairValid            = pv_reg;
endmodule

// ----------------------------------------
// One converter channel: input, stage and converter latches
// ----------------------------------------
module channel_latch_path #(
  parameter int WIDTH = `WORD_W
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             clkEn,
  // Latch controls and the shared bus word
  input  wire logic             capture,
  input  wire logic             stage,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] word,
  // Code and its complement
  output logic [WIDTH-1:0]      code,
  output logic [WIDTH-1:0]      compCode
);
  import dual_dac_pkg::*;

  logic [WIDTH-1:0] in_reg, in_next;
  logic [WIDTH-1:0] st_reg, st_next;
  logic [WIDTH-1:0] cv_reg, cv_next;
  logic [WIDTH-1:0] cmp_reg, cmp_next;

  always_comb begin
    // Input recirculates when not captured
    in_next = in_reg;
    st_next = st_reg;
    cv_next = cv_reg;
    if (capture) begin
      in_next = word;
    end
    if (stage) begin
      st_next = in_reg;
    end
    if (load) begin
      cv_next = st_reg;
    end
    // Bitwise inverse equals 16383 minus code, no subtractor needed
    cmp_next = ~cv_next;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      in_reg  <= '0;
      st_reg  <= '0;
      cv_reg  <= '0;
      cmp_reg <= '1;
    end else if (clkEn) begin
      in_reg  <= in_next;
      st_reg  <= st_next;
      cv_reg  <= cv_next;
      cmp_reg <= cmp_next;
    end
  end

  assign code     = cv_reg;
  assign compCode = cmp_reg;
endmodule
`default_nettype wire

// ### rtl/interleaved_source.sv
// Source end: feeds A/B word pairs through a two-entry buffer onto the bus
`timescale 1ns/1ps
`default_nettype none
`include "dual_dac_cfg.svh"
module interleaved_source #(
  parameter int WIDTH = `WORD_W
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 clkEn,
  // User sample pairs
  input  wire logic [WIDTH-1:0]     sampleA,
  input  wire logic [WIDTH-1:0]     sampleB,
  input  wire logic                 sampleValid,
  output logic                      sampleReady,
  // Link to the converter
  interleaved_bus_if.source         link
);
  import dual_dac_pkg::*;

  // ----------------------------------------
  // Two-entry pair buffer
  // ----------------------------------------
  logic [2*WIDTH-1:0] buf_reg [2];
  logic [2*WIDTH-1:0] buf_next [2];
  logic [1:0] cnt_reg, cnt_next;
  logic       rdy_reg, rdy_next;
  logic       push, pop;

  // ----------------------------------------
  // Bus sequencer, an align state then one state per word, two phases each
  // ----------------------------------------
  src_state_t st_reg, st_next;
  logic [3:0] tim_reg, tim_next;
  logic [2*WIDTH-1:0] cur_reg, cur_next;
  logic wrt_reg, wrt_next, upd_reg, upd_next, sel_reg, sel_next;
  logic [WIDTH-1:0] bus_reg, bus_next;
  logic rsto_reg, rsto_next, phase_reg, phase_next;

  assign push = sampleValid && rdy_reg;
  assign pop  = (cnt_reg != 2'h0) && st_reg == SRC_WORD_B && tim_reg == 4'h0 && phase_reg;

  always_comb begin
    buf_next[0] = buf_reg[0];
    buf_next[1] = buf_reg[1];
    cnt_next    = cnt_reg;
    if (pop) begin
      buf_next[0] = buf_reg[1];
      cnt_next    = cnt_next - 2'h1;
    end
    if (push) begin
      buf_next[cnt_next[0]] = {sampleA, sampleB};
      cnt_next = cnt_next + 2'h1;
    end
    rdy_next = (cnt_next != 2'h2);
  end

  always_comb begin
    st_next    = st_reg;
    tim_next   = tim_reg;
    cur_next   = cur_reg;
    wrt_next   = wrt_reg;
    upd_next   = upd_reg;
    sel_next   = sel_reg;
    bus_next   = bus_reg;
    rsto_next  = rsto_reg;
    phase_next = phase_reg;
    if (tim_reg != 4'h0) begin
      tim_next = tim_reg - 4'h1;
    end else begin
      tim_next   = `HALF_PERIOD;
      phase_next = ~phase_reg;
      // Clock and strobe toggle together so edge order holds
      wrt_next = ~phase_reg;
      upd_next = ~phase_reg;
      case (st_reg)
        SRC_ALIGN: begin
          rsto_next = 1'b1;
          if (phase_reg) begin
            st_next  = SRC_WORD_A;
            cur_next = buf_reg[0];
          end
        end
        SRC_WORD_A: begin
          if (!phase_reg) begin
            sel_next = 1'b1;
            bus_next = cur_reg[2*WIDTH-1:WIDTH];
          end else begin
            st_next = SRC_WORD_B;
          end
        end
        SRC_WORD_B: begin
          if (!phase_reg) begin
            sel_next = 1'b0;
            bus_next = cur_reg[WIDTH-1:0];
          end else begin
            rsto_next = 1'b0;
            st_next   = SRC_WORD_A;
            cur_next  = (cnt_reg != 2'h0) ? buf_reg[0] : cur_reg;
          end
        end
        default: st_next = SRC_ALIGN;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      buf_reg[0] <= '0;
      buf_reg[1] <= '0;
      cnt_reg    <= 2'h0;
      rdy_reg    <= 1'b0;
      st_reg     <= SRC_ALIGN;
      tim_reg    <= `ALIGN_CYCLES;
      cur_reg    <= '0;
      wrt_reg    <= 1'b0;
      upd_reg    <= 1'b0;
      sel_reg    <= 1'b0;
      bus_reg    <= '0;
      rsto_reg   <= 1'b1;
      phase_reg  <= 1'b0;
    end else if (clkEn) begin
      buf_reg    <= buf_next;
      cnt_reg    <= cnt_next;
      rdy_reg    <= rdy_next;
      st_reg     <= st_next;
      tim_reg    <= tim_next;
      cur_reg    <= cur_next;
      wrt_reg    <= wrt_next;
      upd_reg    <= upd_next;
      sel_reg    <= sel_next;
      bus_reg    <= bus_next;
      rsto_reg   <= rsto_next;
      phase_reg  <= phase_next;
    end
  end

  assign sampleReady            = rdy_reg;
  assign link.sharedWriteStrobe = wrt_reg;
  assign link.sharedUpdateClock = upd_reg;
  assign link.channelSelect     = sel_reg;
  assign link.pairAlignReset    = rsto_reg;
  assign link.digitalGroundPin  = `MODE_INTERLEAVED;
  assign link.busA              = bus_reg;
  // Unused bus carries the inverted bus word so that ignoring it is observable
  assign link.busB              = ~bus_reg;
endmodule
`default_nettype wire

// ### sim/interleaved_link_chk.sv
// Concurrent checks on the interleaved link and converter outputs
`timescale 1ns/1ps
`default_nettype none
module interleaved_link_chk #(
  parameter int WIDTH = 14
) (
  // Clock and reset
  input wire logic             clk,
  input wire logic             rst,
  input wire logic             clkEn,
  // Link signals
  input wire logic             sharedWriteStrobe,
  input wire logic             sharedUpdateClock,
  input wire logic             pairAlignReset,
  input wire logic             digitalGroundPin,
  // Converter outputs
  input wire logic [WIDTH-1:0] convCodeA,
  input wire logic [WIDTH-1:0] convCodeB,
  input wire logic [WIDTH-1:0] compCodeA,
  input wire logic [WIDTH-1:0] compCodeB,
  input wire logic             halvedConverterClock,
  input wire logic             interleavedMode,
  input wire logic             pairValid
);
  default clocking cb @(posedge clk); endclocking
  // Frozen cycles stretch every timing window, so checks pause with the enable
  default disable iff (rst || !clkEn);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  hold_low_a: assert property (pairAlignReset |-> !halvedConverterClock)
    else $error("halved clock high during pair reset");
  comp_a_a: assert property (compCodeA == {WIDTH{1'b1}} - convCodeA)
    else $error("channel A complement wrong");
  comp_b_a: assert property (compCodeB == {WIDTH{1'b1}} - convCodeB)
    else $error("channel B complement wrong");
  edge_order_a: assert property (sharedWriteStrobe == sharedUpdateClock)
    else $error("strobe and update clock apart");
  mode_sel_a: assert property (!digitalGroundPin |=> interleavedMode)
    else $error("interleaved mode not entered");
  pulse_once_a: assert property (pairValid |=> !pairValid)
    else $error("pair valid longer than one cycle");
  code_load_a: assert property (
    $changed(convCodeA) || $changed(convCodeB) |-> pairValid)
    else $error("codes changed without a new pair");
  half_rate_a: assert property (
    $rose(halvedConverterClock) |-> ##12 $rose(halvedConverterClock))
    else $error("halved clock period not twelve cycles");
  load_after_a: assert property ($rose(halvedConverterClock) |-> ##[0:2] pairValid)
    else $error("no load after halved clock rise");
  align_start_a: assert property (
    $fell(pairAlignReset) |-> ##[1:30] $rose(halvedConverterClock))
    else $error("divider did not start after pair reset");
  // ----------------------------------------
  // Covers
  // ----------------------------------------
  pair_c: cover property (pairValid);
  align_c: cover property ($fell(pairAlignReset));
  div_c: cover property ($rose(halvedConverterClock));
endmodule
`default_nettype wire

// ### sim/interleaved_dual_dac_input_port_test.sv
// Testbench joining source and converter ends over the interleaved link
`timescale 1ns/1ps
`default_nettype none
module interleaved_dual_dac_input_port_test;
  import dual_dac_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic  clk         = 1'b0;
  logic  rst         = 1'b1;
  logic  clkEn       = 1'b1;
  word_t sampleA     = 14'h0000;
  word_t sampleB     = 14'h0000;
  logic  sampleValid = 1'b0;
  logic  sampleReady;
  word_t convCodeA, convCodeB, compCodeA, compCodeB;
  logic  halvedConverterClock, interleavedMode, pairValid;
  int    fail_count  = 0;
  int    num_checks  = 0;
  int    cycles      = 0;
  logic  sawStall    = 1'b0;
  logic  [1:0] frozen = 2'h0;
  word_t lastA       = 14'h0000;
  word_t lastB       = 14'h0000;
  word_t qA[$];
  word_t qB[$];
  word_t tabA[6] = '{14'h0000, 14'h3FFF, 14'h2000, 14'h0001, 14'h1FFF, 14'h3FFE};
  word_t tabB[6] = '{14'h3FFF, 14'h0000, 14'h1FFF, 14'h3FFE, 14'h2000, 14'h0001};
  always #12.5 clk = ~clk;
  interleaved_bus_if bus ();
  interleaved_source u_interleaved_source (.clk(clk), .rst(rst), .clkEn(clkEn),
    .sampleA(sampleA), .sampleB(sampleB), .sampleValid(sampleValid),
    .sampleReady(sampleReady), .link(bus));
  interleaved_dac_port u_interleaved_dac_port (.clk(clk), .rst(rst), .clkEn(clkEn),
    .link(bus), .convCodeA(convCodeA), .convCodeB(convCodeB), .compCodeA(compCodeA),
    .compCodeB(compCodeB), .halvedConverterClock(halvedConverterClock),
    .interleavedMode(interleavedMode), .pairValid(pairValid));
  interleaved_link_chk u_interleaved_link_chk (.clk(clk), .rst(rst), .clkEn(clkEn),
    .sharedWriteStrobe(bus.sharedWriteStrobe), .sharedUpdateClock(bus.sharedUpdateClock),
    .pairAlignReset(bus.pairAlignReset), .digitalGroundPin(bus.digitalGroundPin),
    .convCodeA(convCodeA), .convCodeB(convCodeB), .compCodeA(compCodeA),
    .compCodeB(compCodeB), .halvedConverterClock(halvedConverterClock),
    .interleavedMode(interleavedMode), .pairValid(pairValid));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Entered at a falling edge; valid stays up so back-to-back calls never double-drive
  task automatic send_pair(input word_t a, input word_t b);
    logic rdy;
    rdy = 1'b0;
    sampleA = a;
    sampleB = b;
    sampleValid = 1'b1;
    qA.push_back(a);
    qB.push_back(b);
    for (int i = 0; i < 200 && !rdy; i++) begin
      rdy = (sampleReady === 1'b1);
      if (!rdy) sawStall = 1'b1;
      @(negedge clk);
    end
    check(rdy, 1'b1);
  endtask
  task automatic drain();
    for (int i = 0; i < 400 && qA.size() > 0; i++) @(negedge clk);
    check(16'(qA.size()), 16'h0000);
  endtask
  task automatic in_reset();
    repeat (2) @(negedge clk);
    check(convCodeA, 14'h0000);
    check(compCodeB, 14'h3FFF);
    check(pairValid, 1'b0);
    check(halvedConverterClock, 1'b0);
    check(bus.pairAlignReset, 1'b1);
    rst = 1'b0;
  endtask
  // ----------------------------------------
  // Scoreboard and watchdog
  // ----------------------------------------
  // Source repeats its last pair when starved, so a repeat is legal
  always @(negedge clk) begin
    if (rst) begin
      lastA = 14'h0000;
      lastB = 14'h0000;
    end else if (pairValid === 1'b1) begin
      if (qA.size() > 0 && convCodeA === qA[0] && convCodeB === qB[0]) begin
        lastA = qA.pop_front();
        lastB = qB.pop_front();
      end
      check(convCodeA, lastA);
      check(convCodeB, lastB);
      check(compCodeA, 14'h3FFF - lastA);
      check(compCodeB, 14'h3FFF - lastB);
    end
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      print_verdict();
    end
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    in_reset();
    repeat (4) @(negedge clk);
    check(interleavedMode, 1'b1);
    check(bus.digitalGroundPin, 1'b0);
    $display("test reset_mode done");
    for (int i = 0; i < 6; i++) send_pair(tabA[i], tabB[i]);
    sampleValid = 1'b0;
    drain();
    check(sawStall, 1'b1);
    $display("test stream done");
    send_pair(14'h1234, 14'h2BCD);
    sampleValid = 1'b0;
    clkEn = 1'b0;
    frozen = {bus.sharedWriteStrobe, halvedConverterClock};
    repeat (12) @(negedge clk);
    check({bus.sharedWriteStrobe, halvedConverterClock}, frozen);
    check(convCodeA, lastA);
    clkEn = 1'b1;
    $display("test freeze done");
    repeat (3) @(negedge clk);
    rst = 1'b1;
    qA.delete();
    qB.delete();
    in_reset();
    repeat (4) @(negedge clk);
    send_pair(14'h0ABC, 14'h3210);
    send_pair(14'h3001, 14'h0FFE);
    sampleValid = 1'b0;
    drain();
    $display("test realign done");
    print_verdict();
  end
endmodule
`default_nettype wire
